// File: design/line_trigger_sync_cfg.svh
// Purpose: constants for the line trigger sync control stage
// Assumes: 100 MHz core_clk
// Notes:   bit positions of the sync control register and reset values
`ifndef LINE_TRIGGER_SYNC_CFG_SVH
`define LINE_TRIGGER_SYNC_CFG_SVH
`define TSC_RESET            8'h00
`define TSC_DIAG_LO          0
`define TSC_DIAG_HI          1
`define TSC_SCAN_SRC         2
`define TSC_HYST_LO          3
`define TSC_HYST_HI          4
`define TSC_FOUR_EDGE        5
`define TSC_BIDIR            6
`define TSC_ADV_EN           7
`define HYST_STEP_4          8'h04
`define HYST_STEP_16         8'h10
`define HYST_STEP_64         8'h40
`define DIVIDER_MAX          15'h7FFF
`define DIVIDER_RESET        15'h0001
`define ACK_OK               1'b0
`define ACK_FAIL             1'b1
`define READ_DIGITS          5
`define DIGIT_ZERO           8'h30
`endif

// File: design/line_trigger_sync_pkg.sv
// Purpose: types for the line trigger sync control stage
// Assumes: nothing beyond the cfg header
// Notes:   one-hot state codes are written out
package line_trigger_sync_pkg;
    typedef enum logic [3:0] {
        TM_LINE_BEGIN     = 4'h1,
        TM_EXPOSURE_BEGIN = 4'h2,
        TM_EXT_SCAN_BEGIN = 4'h4,
        TM_OTHER          = 4'h8
    } trig_mode_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_SEND = 2'h2
    } rd_state_t;
endpackage

// File: design/line_trigger_sync_control.sv
// Purpose: encoder conditioning, divider, line counter and diagnostic pixels
// Assumes: inputs synchronous to core_clk; command parser outside
// Notes:   read answer is five ASCII digits, label prepended by the parser
// Function
// R1: set command loads 8-bit value, acks 0/1
// R2: read returns value as five ASCII digits
// R3: diag bits 00 give normal pixels
// R4: diag 01 puts input states in pixel one
// R5: diag 10 puts counter low byte in pixel one
// R6: diag 11 puts states plus 13-bit counter
// R7: bit2 picks scan begin source A or B
// R8: bits 4:3 pick hysteresis 0/4/16/64; code applies it only when bit6 is also set
// R9: bit5 selects A fall or four edges
// R10: bit6 allows reverse direction pulses
// R11: bit7 clear disables advanced functions
// R12: basic mode uses input A only
// R13: pulses pass through programmable divider
// R14: level of B gives direction
// R15: divider accepts 1 to 32767
// R16: scan begin selection applies in mode 5
// R17: line counter 13 bits, wraps
`include "line_trigger_sync_cfg.svh"
module line_trigger_sync_control #(
    parameter int CNT_W = 13,
    parameter int DIV_W = 15
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // control register command port
    input  wire logic                 ctrl_wr,
    input  wire logic [9:0]           ctrl_wdata,
    output logic                      ctrl_ack,
    output logic                      ctrl_ack_status,
    input  wire logic                 ctrl_rd,
    output logic                      rd_char_valid,
    output logic [7:0]                rd_char,
    output logic [7:0]                trigger_sync_control,
    // divider command
    input  wire logic                 div_wr,
    input  wire logic [15:0]          div_wdata,
    output logic                      div_ack,
    output logic                      div_ack_status,
    // trigger mode and sync inputs
    input  line_trigger_sync_pkg::trig_mode_t trig_mode,
    input  wire logic                 line_sync_a,
    input  wire logic                 line_sync_b,
    input  wire logic                 frame_sync,
    // triggers out
    output logic                      line_trigger,
    output logic                      scan_begin,
    // pixel path
    input  wire logic                 line_done,
    input  wire logic                 pix_first,
    input  wire logic                 pix_second,
    input  wire logic [15:0]          pix_in,
    output logic [15:0]               pix_out,
    output logic [CNT_W-1:0]          line_count
);
    logic [7:0]       tsc_r;
    logic [DIV_W-1:0] div_r;
    logic             a_d_r, b_d_r;
    logic [7:0]       pos_r;
    logic [DIV_W-1:0] div_cnt_r;
    logic [CNT_W-1:0] cnt_r;
    logic [15:0]      pix_r;
    logic             trig_r, sos_r;
    line_trigger_sync_pkg::rd_state_t rd_state_r;
    logic [16:0]      rd_val_r;
    logic [2:0]       rd_idx_r;
    logic [7:0]       rd_char_r;
    logic             rd_valid_r;

    wire logic adv = tsc_r[`TSC_ADV_EN];
    wire logic fall_a = a_d_r & ~line_sync_a;
    wire logic rise_a = ~a_d_r & line_sync_a;
    wire logic fall_b = b_d_r & ~line_sync_b;
    wire logic rise_b = ~b_d_r & line_sync_b;

    // control register write, out-of-range values refused
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tsc_r           <= `TSC_RESET;
            ctrl_ack        <= 1'b0;
            ctrl_ack_status <= `ACK_OK;
        end else begin
            ctrl_ack <= ctrl_wr;
            if (ctrl_wr) begin
                if (ctrl_wdata <= 10'h0FF) begin
                    tsc_r           <= ctrl_wdata[7:0]; // R1
                    ctrl_ack_status <= `ACK_OK;
                end else begin
                    ctrl_ack_status <= `ACK_FAIL; // R1
                end
            end
        end
    end
    assign trigger_sync_control = tsc_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_r          <= `DIVIDER_RESET;
            div_ack        <= 1'b0;
            div_ack_status <= `ACK_OK;
        end else begin
            div_ack <= div_wr;
            if (div_wr) begin
                if (div_wdata != 16'h0000 && div_wdata <= {1'b0, `DIVIDER_MAX}) begin
                    div_r          <= div_wdata[DIV_W-1:0]; // R15
                    div_ack_status <= `ACK_OK;
                end else begin
                    div_ack_status <= `ACK_FAIL; // R15
                end
            end
        end
    end

    // read: five digits, most significant first, one per cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_state_r <= line_trigger_sync_pkg::RD_IDLE;
            rd_val_r   <= 17'h00000;
            rd_idx_r   <= 3'h0;
            rd_char_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= 1'b0;
            case (rd_state_r)
                line_trigger_sync_pkg::RD_IDLE: begin
                    if (ctrl_rd) begin
                        rd_val_r   <= {9'h000, tsc_r};
                        rd_idx_r   <= 3'h0;
                        rd_state_r <= line_trigger_sync_pkg::RD_SEND;
                    end
                end
                line_trigger_sync_pkg::RD_SEND: begin
                    rd_char_r  <= `DIGIT_ZERO + 8'(rd_val_r / 17'(10000)); // R2
                    rd_valid_r <= 1'b1;
                    rd_val_r   <= 17'((rd_val_r % 17'(10000)) * 17'(10));
                    rd_idx_r   <= rd_idx_r + 3'h1;
                    if (rd_idx_r == 3'(`READ_DIGITS - 1))
                        rd_state_r <= line_trigger_sync_pkg::RD_IDLE;
                end
                default: rd_state_r <= line_trigger_sync_pkg::RD_IDLE;
            endcase
        end
    end
    assign rd_char       = rd_char_r;
    assign rd_char_valid = rd_valid_r;

    // edge qualification and direction
    logic       ev_fwd, ev_rev;
    logic [7:0] hyst;
    always_comb begin
        ev_fwd = 1'b0;
        ev_rev = 1'b0;
        if (!adv) begin
            ev_fwd = fall_a; // R11 R12
        end else if (!tsc_r[`TSC_FOUR_EDGE]) begin
            ev_fwd = fall_a & ~line_sync_b; // R9 R14
            ev_rev = fall_a & line_sync_b;  // R14
        end else begin
            // quadrature: B leads A going forward
            ev_fwd = (fall_a & ~line_sync_b) | (rise_a & line_sync_b) |
                     (fall_b & line_sync_a) | (rise_b & ~line_sync_a); // R9
            ev_rev = (fall_a & line_sync_b) | (rise_a & ~line_sync_b) |
                     (fall_b & ~line_sync_a) | (rise_b & line_sync_a);
        end
        if (!tsc_r[`TSC_BIDIR] || !adv)
            ev_rev = 1'b0; // R10
        case (tsc_r[`TSC_HYST_HI:`TSC_HYST_LO])
            2'h1:    hyst = `HYST_STEP_4; // R8
            2'h2:    hyst = `HYST_STEP_16;
            2'h3:    hyst = `HYST_STEP_64;
            default: hyst = 8'h00;
        endcase
        if (!adv)
            hyst = 8'h00;
    end

    // hysteresis, with bit6 set only: after reversal, forward pulses are swallowed until the
    // position climbs back past the reversal point or by the window, whichever comes first
    logic pulse;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            a_d_r <= 1'b1;
            b_d_r <= 1'b1;
            pos_r <= 8'h00;
        end else begin
            a_d_r <= line_sync_a;
            b_d_r <= line_sync_b;
            if (ev_rev && !tsc_r[`TSC_BIDIR])
                pos_r <= pos_r;
            else if (ev_fwd && pos_r != 8'h00)
                pos_r <= pos_r - 8'h01; // R8
            else if (ev_rev && pos_r < hyst)
                pos_r <= pos_r + 8'h01;
        end
    end
    assign pulse = (ev_fwd && pos_r == 8'h00) || (ev_rev && hyst == 8'h00 && tsc_r[`TSC_BIDIR]);

    // divider and line counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
            trig_r    <= 1'b0;
            cnt_r     <= '0;
            sos_r     <= 1'b0;
        end else begin
            trig_r <= 1'b0;
            if (pulse) begin
                if (div_cnt_r + DIV_W'(1) >= div_r) begin
                    div_cnt_r <= '0;
                    trig_r    <= 1'b1; // R13
                end else begin
                    div_cnt_r <= div_cnt_r + DIV_W'(1);
                end
            end
            if (line_done)
                cnt_r <= cnt_r + CNT_W'(1); // R17
            sos_r <= (trig_mode == line_trigger_sync_pkg::TM_EXT_SCAN_BEGIN) &&
                     (tsc_r[`TSC_SCAN_SRC] ? fall_b : fall_a); // R7 R16
        end
    end
    assign line_trigger = trig_r;
    assign scan_begin   = sos_r;
    assign line_count   = cnt_r;

    // diagnostic pixel substitution
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pix_r <= 16'h0000;
        end else begin
            pix_r <= pix_in; // R3
            if (pix_first) begin
                case (tsc_r[`TSC_DIAG_HI:`TSC_DIAG_LO])
                    2'h1: pix_r <= {8'h00, frame_sync, line_sync_a, line_sync_b, 5'h00}; // R4
                    2'h2: pix_r <= {8'h00, cnt_r[7:0]}; // R5
                    2'h3: pix_r <= {8'h00, frame_sync, line_sync_a, line_sync_b, cnt_r[12:8]}; // R6
                    default: pix_r <= pix_in;
                endcase
            end else if (pix_second && tsc_r[`TSC_DIAG_HI:`TSC_DIAG_LO] == 2'h3) begin
                pix_r <= {8'h00, cnt_r[7:0]}; // R6
            end
        end
    end
    assign pix_out = pix_r;

    AST_WRITE_LOADS: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        ctrl_wr && ctrl_wdata <= 10'h0FF |=> tsc_r == $past(ctrl_wdata[7:0]) && ctrl_ack && !ctrl_ack_status)
        else $error("control write not loaded");
    AST_WRITE_REFUSED: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        ctrl_wr && ctrl_wdata > 10'h0FF |=> $stable(tsc_r) && ctrl_ack_status)
        else $error("bad write accepted");
    sequence s_read_start;
        ctrl_rd && rd_state_r == line_trigger_sync_pkg::RD_IDLE;
    endsequence
    AST_READ_FIVE: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        s_read_start |=> !rd_char_valid ##1 rd_char_valid [*5] ##1 !rd_char_valid)
        else $error("read not five digits");
    AST_PIX_NORMAL: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        tsc_r[1:0] == 2'h0 |=> pix_out == $past(pix_in))
        else $error("pixel altered in normal mode");
    AST_PIX_STATES: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        pix_first && tsc_r[1:0] == 2'h1 |=>
        pix_out == {8'h00, $past(frame_sync), $past(line_sync_a), $past(line_sync_b), 5'h00})
        else $error("state pixel wrong");
    AST_PIX_COUNT: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        pix_first && tsc_r[1:0] == 2'h2 |=> pix_out == {8'h00, $past(cnt_r[7:0])})
        else $error("counter pixel wrong");
    AST_PIX_SECOND: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        pix_second && !pix_first && tsc_r[1:0] == 2'h3 |=> pix_out[7:0] == $past(cnt_r[7:0]))
        else $error("second pixel wrong");
    AST_BASIC_A_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
        !adv && !fall_a |-> !pulse)
        else $error("pulse without A falling edge");
    AST_SOS_SRC: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        trig_mode == line_trigger_sync_pkg::TM_EXT_SCAN_BEGIN && tsc_r[2] && fall_b |=> scan_begin)
        else $error("scan begin from B missing");
    AST_COUNT_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
        line_done && cnt_r == '1 |=> cnt_r == '0)
        else $error("counter did not wrap");
endmodule

// File: tb/encoder_source.sv
// Purpose: behavioural machine encoder and frame sync source
// Assumes: levels change 1 ns after a rising core_clk edge
// Notes:   line A rests high between fall_a and fall_b steps, as after reset, while levels leaves it as set; line B keeps the level last set
module encoder_source (
    input  wire logic core_clk,
    output logic      line_sync_a,
    output logic      line_sync_b,
    output logic      frame_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        line_sync_a = 1'b1;
        line_sync_b = 1'b1;
        frame_sync  = 1'b0;
    end
    // b settles before a falls so the edge has a clean direction
    task automatic fall_a(input logic b_lvl);
        @(posedge core_clk) #1 line_sync_b = b_lvl;
        repeat (3) @(posedge core_clk);
        #1 line_sync_a = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 line_sync_a = 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic fall_b;
        @(posedge core_clk) #1 line_sync_b = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 line_sync_b = 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic levels(input logic f, input logic a, input logic b);
        @(posedge core_clk) #1 frame_sync = f;
        line_sync_a = a;
        line_sync_b = b;
    endtask
endmodule

// File: tb/test_line_trigger_sync_control.sv
// Purpose: directed checks of the line trigger sync control stage
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   trigger pulses are tallied by counters, not by the tasks
module test_line_trigger_sync_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst_n, ctrl_wr, ctrl_rd, div_wr, line_done, pix_first, pix_second;
    logic [9:0]  ctrl_wdata;
    logic [15:0] div_wdata, pix_in, pix_out;
    logic        ctrl_ack, ctrl_ack_status, rd_char_valid, div_ack, div_ack_status;
    logic [7:0]  rd_char, trigger_sync_control;
    logic        line_trigger, scan_begin, sa, sb, fs;
    logic [12:0] line_count;
    line_trigger_sync_pkg::trig_mode_t trig_mode;
    int          failures = 0, cmp_count = 0, cyc = 0, ntrig = 0, nscan = 0, n0;
    encoder_source enc (.core_clk(core_clk), .line_sync_a(sa), .line_sync_b(sb), .frame_sync(fs));
    line_trigger_sync_control dut (.core_clk(core_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl_ack(ctrl_ack), .ctrl_ack_status(ctrl_ack_status),
        .ctrl_rd(ctrl_rd), .rd_char_valid(rd_char_valid), .rd_char(rd_char),
        .trigger_sync_control(trigger_sync_control), .div_wr(div_wr), .div_wdata(div_wdata),
        .div_ack(div_ack), .div_ack_status(div_ack_status), .trig_mode(trig_mode),
        .line_sync_a(sa), .line_sync_b(sb), .frame_sync(fs), .line_trigger(line_trigger),
        .scan_begin(scan_begin), .line_done(line_done), .pix_first(pix_first),
        .pix_second(pix_second), .pix_in(pix_in), .pix_out(pix_out), .line_count(line_count));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (line_trigger === 1'b1) ntrig++;
        if (scan_begin === 1'b1) nscan++;
        // whole run is about 10k cycles
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] v, input logic st, input logic [7:0] reg_exp);
        @(posedge core_clk) #1 ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(posedge core_clk) #1 ctrl_wr = 1'b0;
        chk({15'h0000, ctrl_ack}, 16'h0001);
        chk({15'h0000, ctrl_ack_status}, {15'h0000, st});
        chk({8'h00, trigger_sync_control}, {8'h00, reg_exp});
    endtask
    task automatic dw(input logic [15:0] v, input logic st);
        @(posedge core_clk) #1 div_wr = 1'b1;
        div_wdata = v;
        @(posedge core_clk) #1 div_wr = 1'b0;
        chk({14'h0000, div_ack, div_ack_status}, {14'h0000, 1'b1, st});
    endtask
    task automatic rd(input logic [39:0] s);
        @(posedge core_clk) #1 ctrl_rd = 1'b1;
        @(posedge core_clk) #1 ctrl_rd = 1'b0;
        chk({15'h0000, rd_char_valid}, 16'h0000);
        for (int i = 4; i >= 0; i--) begin
            @(posedge core_clk) #1;
            chk({7'h00, rd_char_valid, rd_char}, {8'h01, s[i*8+:8]});
        end
    endtask
    task automatic pix(input logic first, input logic [15:0] din, input logic [15:0] exp);
        @(posedge core_clk) #1 pix_first = first;
        pix_second = ~first;
        pix_in = din;
        @(posedge core_clk) #1 pix_first = 1'b0;
        pix_second = 1'b0;
        chk(pix_out, exp);
    endtask
    task automatic set_mode(input line_trigger_sync_pkg::trig_mode_t m);
        @(posedge core_clk) #1 trig_mode = m;
    endtask
    task automatic lines(input int n);
        @(posedge core_clk) #1 line_done = 1'b1;
        repeat (n) @(posedge core_clk);
        #1 line_done = 1'b0;
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rst_n, ctrl_wr, ctrl_rd, div_wr, line_done, pix_first, pix_second} = 7'h00;
        ctrl_wdata = 10'h000;
        div_wdata = 16'h0000;
        pix_in = 16'hABCD;
        trig_mode = line_trigger_sync_pkg::TM_LINE_BEGIN;
        repeat (10) @(posedge core_clk);
        #1 rst_n = 1'b1;
        chk({8'h00, trigger_sync_control}, 16'h0000);
        wr(10'h0E8, 1'b0, 8'hE8);
        wr(10'h12C, 1'b1, 8'hE8);
        rd("00232");
        wr(10'h000, 1'b0, 8'h00);
        dw(16'h0000, 1'b1);
        dw(16'h8000, 1'b1);
        dw(16'h0002, 1'b0);
        n0 = ntrig;
        repeat (4) enc.fall_a(1'b1);
        chk(16'(ntrig - n0), 16'h0002);
        dw(16'h0001, 1'b0);
        wr(10'h080, 1'b0, 8'h80);
        n0 = ntrig;
        repeat (2) enc.fall_a(1'b0);
        repeat (2) enc.fall_a(1'b1);
        chk(16'(ntrig - n0), 16'h0002);
        wr(10'h0C0, 1'b0, 8'hC0);
        n0 = ntrig;
        enc.fall_a(1'b0);
        enc.fall_a(1'b1);
        chk(16'(ntrig - n0), 16'h0002);
        wr(10'h0C8, 1'b0, 8'hC8);
        n0 = ntrig;
        repeat (2) enc.fall_a(1'b1);
        repeat (3) enc.fall_a(1'b0);
        chk(16'(ntrig - n0), 16'h0001);
        wr(10'h0D0, 1'b0, 8'hD0);
        n0 = ntrig;
        repeat (17) enc.fall_a(1'b1);
        repeat (17) enc.fall_a(1'b0);
        chk(16'(ntrig - n0), 16'h0001);
        wr(10'h0D8, 1'b0, 8'hD8);
        n0 = ntrig;
        repeat (65) enc.fall_a(1'b1);
        repeat (66) enc.fall_a(1'b0);
        chk(16'(ntrig - n0), 16'h0002);
        // quadrature, four steps forward then four back, reverse ignored
        wr(10'h0A0, 1'b0, 8'hA0);
        n0 = ntrig;
        enc.levels(1'b0, 1'b0, 1'b0);
        enc.levels(1'b0, 1'b0, 1'b1);
        enc.levels(1'b0, 1'b1, 1'b1);
        enc.levels(1'b0, 1'b1, 1'b0);
        enc.levels(1'b0, 1'b1, 1'b1);
        enc.levels(1'b0, 1'b0, 1'b1);
        enc.levels(1'b0, 1'b0, 1'b0);
        enc.levels(1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge core_clk);
        chk(16'(ntrig - n0), 16'h0004);
        set_mode(line_trigger_sync_pkg::TM_EXPOSURE_BEGIN);
        wr(10'h048, 1'b0, 8'h48);
        n0 = ntrig;
        repeat (2) enc.fall_a(1'b1);
        chk(16'(ntrig - n0), 16'h0002);
        chk(16'(nscan), 16'h0000);
        set_mode(line_trigger_sync_pkg::TM_EXT_SCAN_BEGIN);
        wr(10'h004, 1'b0, 8'h04);
        n0 = nscan;
        enc.fall_b();
        enc.fall_a(1'b1);
        chk(16'(nscan - n0), 16'h0001);
        wr(10'h000, 1'b0, 8'h00);
        enc.fall_a(1'b1);
        chk(16'(nscan - n0), 16'h0002);
        lines(259);
        chk({3'h0, line_count}, 16'h0103);
        enc.levels(1'b1, 1'b1, 1'b0);
        pix(1'b1, 16'h1234, 16'h1234);
        pix(1'b0, 16'h5678, 16'h5678);
        wr(10'h001, 1'b0, 8'h01);
        pix(1'b1, 16'h9ABC, 16'h00C0);
        pix(1'b0, 16'h7531, 16'h7531);
        wr(10'h002, 1'b0, 8'h02);
        pix(1'b1, 16'hDEF0, 16'h0003);
        pix(1'b0, 16'h2468, 16'h2468);
        wr(10'h003, 1'b0, 8'h03);
        pix(1'b1, 16'h1357, 16'h00C1);
        pix(1'b0, 16'hFEDC, 16'h0003);
        lines(7933);
        chk({3'h0, line_count}, 16'h0000);
        final_report();
    end
endmodule
